// ===== logic/jtp_defs.svh
`ifndef JTP_DEFS_SVH
`define JTP_DEFS_SVH
// ----------------------------------------
// clock and instruction codes
// ----------------------------------------
`define JTP_CLK_MHZ      250
`define JTP_IR_W         4
`define JTP_IR_IDCODE    4'h1
`define JTP_IR_ENABLE    4'h9
`define JTP_IR_ERASE     4'ha
`define JTP_IR_PROGRAM   4'hb
`define JTP_IR_VERIFY    4'hc
`define JTP_IR_BYPASS    4'hf
`define JTP_IR_CAPTURE   4'h1
// ----------------------------------------
// register widths and reset values
// ----------------------------------------
`define JTP_ID_W         32
`define JTP_IDCODE_DEF   32'h0000_0001
`define JTP_ADDR_W       4
`define JTP_DATA_W       32
`define JTP_ROWS         16
`define JTP_FIFO_DEPTH   16
`define JTP_CFG_ROW      0
`define JTP_CFG_BIT      0
// ----------------------------------------
// pin positions on the four-pin port
// ----------------------------------------
`define JTP_PIN_TCK      0
`define JTP_PIN_TMS      1
`define JTP_PIN_TDI      2
`define JTP_PIN_TDO      3
// ----------------------------------------
// array pulse times and their cycle counts
// ----------------------------------------
`define JTP_PWE_MS       100
`define JTP_PWP_MS       10
`define JTP_PWV_US       10
`define JTP_ERASE_CYC    (`JTP_PWE_MS * 1000 * `JTP_CLK_MHZ)
`define JTP_PROG_CYC     (`JTP_PWP_MS * 1000 * `JTP_CLK_MHZ)
`define JTP_VERIFY_CYC   (`JTP_PWV_US * `JTP_CLK_MHZ)
`endif

// ===== logic/jtp_pkg.sv
`default_nettype none
`include "jtp_defs.svh"
package jtp_pkg;
  // ----------------------------------------
  // controller states and register choice
  // ----------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jtp_tap_e;
  typedef enum logic [1:0] {DR_BYPASS, DR_IDCODE, DR_ISP} jtp_dr_e;
  typedef enum logic [1:0] {OP_ERASE, OP_PROGRAM, OP_VERIFY} jtp_op_e;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    jtp_op_e                 op;
    logic [`JTP_ADDR_W-1:0]  addr;
    logic [`JTP_DATA_W-1:0]  data;
  } jtp_cmd_s;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_pins_s;
endpackage
`default_nettype wire

// ===== logic/jtp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module jtp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  // depth must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // storage has no reset, only the pointers define contents
  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointer advance on each accepted word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/jtp_nvm.sv
`timescale 1ns/1ns
`default_nettype none
`include "jtp_defs.svh"
module jtp_nvm #(
  parameter int unsigned ERASE_CYC  = `JTP_ERASE_CYC,
  parameter int unsigned PROG_CYC   = `JTP_PROG_CYC,
  parameter int unsigned VERIFY_CYC = `JTP_VERIFY_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire jtp_pkg::jtp_cmd_s      cmd,
  output logic                        rd_valid,
  output logic     [`JTP_DATA_W-1:0]  rd_data,
  output logic                        busy,
  output logic                        tap_on
);
  import jtp_pkg::*;
  // factory state is erased, so the config bit leaves the port enabled
  logic [`JTP_DATA_W-1:0] mem [`JTP_ROWS] = '{default: '1};
  logic [31:0]            cnt;
  jtp_cmd_s               cur;
  logic                   done;

  function automatic logic [31:0] op_cycles(input jtp_op_e op);
    unique case (op)
      OP_ERASE:   op_cycles = ERASE_CYC;
      OP_PROGRAM: op_cycles = PROG_CYC;
      default:    op_cycles = VERIFY_CYC;
    endcase
  endfunction

  assign cmd_ready = !busy;
  assign done      = busy && (cnt == 32'd0);
  assign tap_on    = mem[`JTP_CFG_ROW][`JTP_CFG_BIT];

  // one operation at a time; the pulse length is counted out in full
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      cnt  <= 32'd0;
      cur  <= '0;
    end else if (!busy && cmd_valid) begin
      busy <= 1'b1;
      cur  <= cmd;
      cnt  <= op_cycles(cmd.op) - 32'd1;
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 32'd1;
    end
  end

  // array update at the end of the pulse; no reset, the cells are nonvolatile
  always_ff @(posedge ref_clk) begin
    if (done && cur.op == OP_ERASE) begin
      for (int i = 0; i < `JTP_ROWS; i++) begin
        mem[i] <= '1;  // see RULE16
      end
    end else if (done && cur.op == OP_PROGRAM) begin
      mem[cur.addr] <= cur.data;  // see RULE18
    end
  end

  // readback of the addressed row
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= done && (cur.op == OP_VERIFY);
      if (done && cur.op == OP_VERIFY) begin
        rd_data <= mem[cur.addr];  // see RULE18
      end
    end
  end

  AST_PROG_ROW: assert property (@(posedge ref_clk) disable iff (reset) // see RULE18
    done && cur.op == OP_PROGRAM |=> mem[$past(cur.addr)] == $past(cur.data))
    else $error("program did not write the addressed row");
  AST_ERASE_ALL: assert property (@(posedge ref_clk) disable iff (reset) // see RULE16
    done && cur.op == OP_ERASE |=> mem[`JTP_ROWS-1] == '1 && tap_on)
    else $error("erase left cells programmed");
endmodule
`default_nettype wire

// ===== logic/jtp_tap_isp_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "jtp_defs.svh"
// Functional notes
// RULE1 - few instructions, yet behaves correctly as one link of a scan chain
// RULE2 - port is four pins only: clock, mode, data in, data out; no test reset
// RULE3 - power-up reset puts the controller into test-logic-reset
// RULE4 - unprogrammed part uses the four pins as test port
// RULE5 - user cells behind the test pins stay usable as buried logic
// RULE6 - configuration with port disabled turns the four pins into general I/O
// RULE7 - code 1111 puts a one-bit bypass stage between data in and out
// RULE8 - scanning all ones into the instruction register loads bypass
// RULE9 - code 0001 shifts the identification value out serially
// RULE10 - data in is sampled on test clock rising edges
// RULE11 - data out changes on test clock falling edges
// RULE12 - data out floats unless shifting out
// RULE13 - controller keeps mode select high during normal operation
// RULE14 - standard sixteen-state controller with four-bit instruction register
// RULE15 - unknown instruction codes select the bypass stage
// RULE16 - 1001 enables programming, 1010 erases whole array, both via program register
// RULE17 - enable must come before erase, program or verify
// RULE18 - 1011 writes addressed row, 1100 reads row back into shift register
module jtp_tap_isp_port #(
  parameter logic [31:0] IDCODE    = `JTP_IDCODE_DEF,  // arbitrary value
  parameter int unsigned ERASE_CYC = `JTP_ERASE_CYC,
  parameter int unsigned PROG_CYC  = `JTP_PROG_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [3:0] pin_i,
  output logic      [3:0] pin_o,
  output logic      [3:0] pin_oe,
  input  wire logic [3:0] user_o,
  input  wire logic [3:0] user_oe,
  output logic      [3:0] user_i,
  output logic            tap_active,
  output logic            isp_enabled,
  output logic            nvm_busy
);
  import jtp_pkg::*;
  localparam int ISP_W = `JTP_ADDR_W + `JTP_DATA_W;

  logic [3:0]             pin_meta;
  logic [3:0]             pin_sync;
  jtp_pins_s              pins;
  logic                   tck_q;
  logic                   tck_rise;
  logic                   tck_fall;
  jtp_tap_e               state;
  jtp_tap_e               next_state;
  logic [3:0]             ir_shift;
  logic [3:0]             ir;
  logic                   isp_en;
  logic                   byp;
  logic [`JTP_ID_W-1:0]   id_sr;
  logic [ISP_W-1:0]       isp_sr;
  logic [`JTP_DATA_W-1:0] readback;
  logic                   tdo;
  logic                   tdo_oe;
  logic                   shift_out;
  logic                   cmd_hit;
  jtp_op_e                cmd_op;
  logic                   pend;
  jtp_cmd_s               pend_cmd;
  logic                   fifo_ready;
  logic                   q_valid;
  logic                   q_ready;
  jtp_cmd_s               q_cmd;
  logic                   rd_valid;
  logic [`JTP_DATA_W-1:0] rd_data;
  logic                   tap_on;
  logic [2:0]             tms_run;

  // register that an instruction places between data in and data out
  function automatic jtp_dr_e dr_sel(input logic [3:0] code);
    case (code)
      `JTP_IR_IDCODE:  dr_sel = DR_IDCODE;
      `JTP_IR_ENABLE,
      `JTP_IR_ERASE,
      `JTP_IR_PROGRAM,
      `JTP_IR_VERIFY:  dr_sel = DR_ISP;
      default:         dr_sel = DR_BYPASS;  // see RULE7, see RULE15
    endcase
  endfunction

  // ----------------------------------------
  // pin synchronisers and test clock edges
  // ----------------------------------------
  // the test clock is far slower than ref_clk, so edges are found by sampling
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // only four pins: no test reset input exists
  assign pins = '{tck: pin_sync[`JTP_PIN_TCK], tms: pin_sync[`JTP_PIN_TMS],
                  tdi: pin_sync[`JTP_PIN_TDI]};  // see RULE2

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= pins.tck;
    end
  end

  assign tck_rise = pins.tck && !tck_q;
  assign tck_fall = !pins.tck && tck_q;

  // ----------------------------------------
  // controller
  // ----------------------------------------
  always_comb begin
    unique case (state)
      TLR:    next_state = pins.tms ? TLR    : RTI;
      RTI:    next_state = pins.tms ? SEL_DR : RTI;
      SEL_DR: next_state = pins.tms ? SEL_IR : CAP_DR;
      CAP_DR: next_state = pins.tms ? EX1_DR : SH_DR;
      SH_DR:  next_state = pins.tms ? EX1_DR : SH_DR;
      EX1_DR: next_state = pins.tms ? UPD_DR : PA_DR;
      PA_DR:  next_state = pins.tms ? EX2_DR : PA_DR;
      EX2_DR: next_state = pins.tms ? UPD_DR : SH_DR;
      UPD_DR: next_state = pins.tms ? SEL_DR : RTI;
      SEL_IR: next_state = pins.tms ? TLR    : CAP_IR;
      CAP_IR: next_state = pins.tms ? EX1_IR : SH_IR;
      SH_IR:  next_state = pins.tms ? EX1_IR : SH_IR;
      EX1_IR: next_state = pins.tms ? UPD_IR : PA_IR;
      PA_IR:  next_state = pins.tms ? EX2_IR : PA_IR;
      EX2_IR: next_state = pins.tms ? UPD_IR : SH_IR;
      UPD_IR: next_state = pins.tms ? SEL_DR : RTI;
    endcase
  end

  // power-up reset stands in for the missing test reset pin
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= TLR;  // see RULE3
    end else if (!tap_on) begin
      state <= TLR;  // see RULE6
    end else if (tck_rise) begin
      state <= next_state;  // see RULE10, see RULE14
    end
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  // capture pattern ends in 01 so a chain can be checked for length
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ir_shift <= 4'h0;
      ir       <= `JTP_IR_IDCODE;
    end else if (state == TLR) begin
      ir <= `JTP_IR_IDCODE;
    end else if (tck_rise && state == CAP_IR) begin
      ir_shift <= `JTP_IR_CAPTURE;  // see RULE1
    end else if (tck_rise && state == SH_IR) begin
      ir_shift <= {pins.tdi, ir_shift[3:1]};  // see RULE8, see RULE10
    end else if (tck_fall && state == UPD_IR) begin
      ir <= ir_shift;  // see RULE14
    end
  end

  // enable persists across programming codes, any other code drops it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      isp_en <= 1'b0;
    end else if (state == TLR) begin
      isp_en <= 1'b0;
    end else if (tck_fall && state == UPD_IR) begin
      isp_en <= (ir_shift == `JTP_IR_ENABLE) ||
                (isp_en && dr_sel(ir_shift) == DR_ISP);  // see RULE16, see RULE17
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      byp    <= 1'b0;
      id_sr  <= '0;
      isp_sr <= '0;
    end else if (tck_rise && state == CAP_DR) begin
      unique case (dr_sel(ir))
        DR_BYPASS: byp <= 1'b0;
        DR_IDCODE: id_sr <= IDCODE;  // see RULE9
        DR_ISP:    isp_sr[`JTP_DATA_W-1:0] <= readback;  // see RULE18
      endcase
    end else if (tck_rise && state == SH_DR) begin
      unique case (dr_sel(ir))
        DR_BYPASS: byp <= pins.tdi;  // see RULE7
        DR_IDCODE: id_sr <= {pins.tdi, id_sr[`JTP_ID_W-1:1]};  // see RULE9
        DR_ISP:    isp_sr <= {pins.tdi, isp_sr[ISP_W-1:1]};  // see RULE10
      endcase
    end
  end

  // verify result waits here until the next capture picks it up
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      readback <= '0;
    end else if (rd_valid) begin
      readback <= rd_data;
    end
  end

  // ----------------------------------------
  // programming commands
  // ----------------------------------------
  always_comb begin
    cmd_hit = 1'b1;
    cmd_op  = OP_VERIFY;
    case (ir)
      `JTP_IR_ERASE:   cmd_op = OP_ERASE;
      `JTP_IR_PROGRAM: cmd_op = OP_PROGRAM;
      `JTP_IR_VERIFY:  cmd_op = OP_VERIFY;
      default:         cmd_hit = 1'b0;
    endcase
  end

  // a full queue holds the command here rather than dropping it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend     <= 1'b0;
      pend_cmd <= '0;
    end else if (tck_fall && state == UPD_DR && cmd_hit && isp_en) begin
      pend     <= 1'b1;  // see RULE17
      pend_cmd <= '{op: cmd_op, addr: isp_sr[ISP_W-1:`JTP_DATA_W],
                    data: isp_sr[`JTP_DATA_W-1:0]};  // see RULE16, see RULE18
    end else if (pend && fifo_ready) begin
      pend <= 1'b0;
    end
  end

  jtp_fifo #(
    .W     ($bits(jtp_cmd_s)),
    .DEPTH (`JTP_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (pend),
    .in_ready  (fifo_ready),
    .in_data   (pend_cmd),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_cmd)
  );

  jtp_nvm #(
    .ERASE_CYC (ERASE_CYC),
    .PROG_CYC  (PROG_CYC)
  ) u_nvm (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .cmd_valid (q_valid),
    .cmd_ready (q_ready),
    .cmd       (q_cmd),
    .rd_valid  (rd_valid),
    .rd_data   (rd_data),
    .busy      (nvm_busy),
    .tap_on    (tap_on)
  );

  // ----------------------------------------
  // serial output and pin sharing
  // ----------------------------------------
  always_comb begin
    if (state == SH_IR) begin
      shift_out = ir_shift[0];
    end else begin
      unique case (dr_sel(ir))
        DR_BYPASS: shift_out = byp;
        DR_IDCODE: shift_out = id_sr[0];
        DR_ISP:    shift_out = isp_sr[0];
        default:   shift_out = byp;
      endcase
    end
  end

  // output moves on the falling edge, giving the next device a full half period
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!tap_on) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= shift_out;  // see RULE11
      tdo_oe <= (state == SH_DR) || (state == SH_IR);  // see RULE12
    end
  end

  // pin inputs on these cells still reach user logic through user_i in either mode
  always_comb begin
    if (tap_on) begin
      pin_o  = 4'h0;
      pin_oe = 4'h0;
      pin_o[`JTP_PIN_TDO]  = tdo;  // see RULE4, see RULE5
      pin_oe[`JTP_PIN_TDO] = tdo_oe;
    end else begin
      pin_o  = user_o;  // see RULE6
      pin_oe = user_oe;
    end
  end

  assign user_i      = pin_sync;  // see RULE5
  assign tap_active  = tap_on;
  assign isp_enabled = isp_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // run of rising edges with mode select high, saturating at five
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tms_run <= 3'd0;
    end else if (tck_rise) begin
      tms_run <= !pins.tms ? 3'd0 : (tms_run == 3'd5) ? 3'd5 : tms_run + 3'd1;
    end
  end

  AST_POR_TLR: assert property (@(posedge ref_clk) disable iff (reset) // see RULE3
    $fell(reset) |-> state == TLR && !tdo_oe && ir == `JTP_IR_IDCODE)
    else $error("controller not in reset after power-up");
  AST_TMS_FIVE: assert property (@(posedge ref_clk) disable iff (reset) // see RULE14
    tms_run == 3'd5 |-> state == TLR)
    else $error("five high mode cycles did not reach reset");
  AST_MOVE_RISE: assert property (@(posedge ref_clk) disable iff (reset) // see RULE10
    state != $past(state) |-> $past(tck_rise) || !$past(tap_on))
    else $error("controller moved without a rising test clock");
  AST_TDO_FALL: assert property (@(posedge ref_clk) disable iff (reset) // see RULE11
    $changed(tdo) |-> $past(tck_fall))
    else $error("data out changed off a falling edge");
  AST_TDO_FLOAT: assert property (@(posedge ref_clk) disable iff (reset) // see RULE12
    tck_fall && state != SH_DR && state != SH_IR |=> !tdo_oe)
    else $error("data out driven outside a shift state");
  AST_IR_CAP: assert property (@(posedge ref_clk) disable iff (reset) // see RULE1
    tck_rise && state == CAP_IR |=> ir_shift == `JTP_IR_CAPTURE && state != CAP_IR)
    else $error("instruction capture pattern wrong");
  AST_ONES_BYP: assert property (@(posedge ref_clk) disable iff (reset) // see RULE8
    tck_fall && state == UPD_IR && ir_shift == 4'hf |=> ir == `JTP_IR_BYPASS && dr_sel(ir) == DR_BYPASS)
    else $error("all ones did not load bypass");
  AST_BYP_OUT: assert property (@(posedge ref_clk) disable iff (reset) // see RULE7
    tck_fall && tap_on && state == SH_DR && dr_sel(ir) == DR_BYPASS |=> tdo == $past(byp) && tdo_oe)
    else $error("bypass stage not on data out");
  AST_ID_CAP: assert property (@(posedge ref_clk) disable iff (reset) // see RULE9
    tck_rise && state == CAP_DR && ir == `JTP_IR_IDCODE |=> id_sr == IDCODE)
    else $error("identification value not captured");
  AST_NEED_EN: assert property (@(posedge ref_clk) disable iff (reset) // see RULE17
    $rose(pend) |-> $past(isp_en) && $past(state) == UPD_DR)
    else $error("programming command without enable");
  AST_GPIO: assert property (@(posedge ref_clk) disable iff (reset) // see RULE6
    !tap_on |-> pin_oe == user_oe && pin_o == user_o)
    else $error("pins not handed to user logic");
endmodule
`default_nettype wire

// ===== bench/jtp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module jtp_ctrl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  // clock parked low outside scans; mode and data rest at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 125 ns test clock: lines move in the low phase, tdo taken at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62 q = tdo;
    tck = 1'b1;
    #63 tck = 1'b0;
  endtask

  // five highs always reach test-logic-reset, whatever the state
  task automatic go_idle();
    logic q;
    repeat (5) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask

  // full scan from run-test-idle back to it; n bits, lsb first
  task automatic scan(input logic ir, input logic [63:0] d, input int n, output logic [63:0] q);
    logic b;
    q = '0;
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tms = 1'b1;
    tdi = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/jtp_tap_isp_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module jtp_tap_isp_port_test;
  import jtp_pkg::*;
  localparam logic [31:0] ID = 32'h1a2b_3c4d; // arbitrary value
  typedef struct packed {
    logic [3:0]  ir;
    logic [63:0] din;
    logic [6:0]  n;
    logic [63:0] exp;
  } jtp_row_s;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  user_o = 4'h0;
  logic [3:0]  user_oe = 4'h0;
  logic [3:0]  pin_i, pin_o, pin_oe, user_i, ext;
  logic        tck, tms, tdi, tap_active, isp_enabled, nvm_busy;
  logic [7:0]  busy_cnt = 8'h0;
  logic [7:0]  n0;
  logic [63:0] q;
  int          failures = 0;
  int          n_checks = 0;
  jtp_row_s    rows [7];

  always #2 ref_clk = ~ref_clk;
  // tdo pad has a pull-up; each pad shows the driver when enabled
  assign ext = {1'b1, tdi, tms, tck};
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
  always @(posedge nvm_busy) busy_cnt <= busy_cnt + 8'h1;
  // tdo may only move while the test clock is low
  always @(pin_o[3]) if (tap_active === 1'b1) chk(tck, 1'b0, "tdo moved");

  jtp_tap_isp_port #(.IDCODE(ID), .ERASE_CYC(20), .PROG_CYC(10)) DUT (
    .ref_clk(ref_clk), .reset(reset), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .user_o(user_o), .user_oe(user_oe), .user_i(user_i), .tap_active(tap_active),
    .isp_enabled(isp_enabled), .nvm_busy(nvm_busy));
  jtp_ctrl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(pin_i[3]));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // load an instruction, then one data scan
  task automatic cmd(input logic [3:0] ir, input logic [35:0] d);
    ctl.scan(1'b1, {60'h0, ir}, 4, q);
    ctl.scan(1'b0, {28'h0, d}, 36, q);
  endtask

  // array ops are slow; bounded wait for the busy flag to drop
  task automatic wait_idle();
    for (int k = 0; k < 4000 && nvm_busy !== 1'b0; k++) @(posedge ref_clk);
    chk(nvm_busy, 1'b0, "busy stuck");
  endtask

  // a hang ends the run the same way as the tests
  initial begin
    #300000;
    failures++;
    final_report();
  end

  initial begin
    rows[0] = '{4'h1, 64'h0, 7'd32, {32'h0, ID}};
    rows[1] = '{4'hf, 64'ha5, 7'd8, 64'h4a};
    rows[2] = '{4'h0, 64'ha5, 7'd8, 64'h4a};
    rows[3] = '{4'h3, 64'ha5, 7'd8, 64'h4a};
    rows[4] = '{4'h6, 64'ha5, 7'd8, 64'h4a};
    rows[5] = '{4'he, 64'ha5, 7'd8, 64'h4a};
    rows[6] = '{4'hd, 64'ha5, 7'd8, 64'h4a};
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    chk({tap_active, isp_enabled, nvm_busy, pin_oe}, 7'h40, "after reset");
    repeat (3) @(posedge ref_clk);
    ctl.go_idle();
    ctl.scan(1'b0, 64'h0, 32, q);
    chk(q[31:0], ID, "id after reset");
    // ----------------------------------------
    // instruction table
    // ----------------------------------------
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk) #1;
      user_o = 4'(i);
      user_oe = ~4'(i);
      ctl.scan(1'b1, {60'h0, rows[i].ir}, 4, q);
      chk(q[3:0], 4'h1, "ir capture");
      ctl.scan(1'b0, rows[i].din, int'(rows[i].n), q);
      chk(q & ((64'h1 << rows[i].n) - 64'h1), rows[i].exp, "dr out");
      chk(pin_oe, 4'h0, "pins driven at idle");
      // pins rest at clock low, mode and data high, data out pulled up; let the sync settle
      repeat (3) @(posedge ref_clk);
      #1 chk(user_i, 4'he, "buried input");
    end
    // ----------------------------------------
    // programming
    // ----------------------------------------
    n0 = busy_cnt;
    cmd(4'hb, {4'h5, 32'h1});
    wait_idle();
    chk(busy_cnt, n0, "program without enable");
    ctl.scan(1'b1, 64'h9, 4, q);
    chk(isp_enabled, 1'b1, "enable");
    cmd(4'ha, 36'h0);
    wait_idle();
    chk(busy_cnt, n0 + 8'h1, "erase ran");
    cmd(4'hb, {4'h5, 32'hcafe_0123});
    wait_idle();
    cmd(4'hc, {4'h5, 32'h0});
    wait_idle();
    ctl.scan(1'b0, {28'h0, 4'h7, 32'h0}, 36, q);
    chk(q[31:0], 32'hcafe_0123, "row readback");
    wait_idle();
    ctl.scan(1'b0, {28'h0, 4'h7, 32'h0}, 36, q);
    chk(q[31:0], 32'hffff_ffff, "erased row");
    wait_idle();
    // ----------------------------------------
    // port switched off by configuration
    // ----------------------------------------
    cmd(4'hb, 36'h0);
    wait_idle();
    @(posedge ref_clk) #1;
    user_o = 4'h6;
    user_oe = 4'hf;
    repeat (4) @(posedge ref_clk);
    chk({tap_active, pin_o, pin_oe}, 9'h06f, "general io");
    chk(user_i, 4'h6, "io readback");
    final_report();
  end
endmodule
`default_nettype wire
